// >>> pwm_core_control.sv
`timescale 1ns/10ps
`default_nettype none

module pwm_core_control
	import pwm_core_control_pkg::*;
(
	// clock and reset
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_n_i,
	// special-function register port
	input  wire sfr_req_t                 sfr_req_i,
	output logic      [7:0]               sfr_rdata_o,
	// clock source choice and timer overflow pulse
	input  wire logic                     pwm_clk_sel_i,
	input  wire logic                     timer_ovf_i,
	// period, duty and selections held by sibling registers
	input  wire logic [CNT_W-1:0]         period_i,
	input  wire logic [NUM_CH-1:0][CNT_W-1:0] duty_i,
	input  wire logic [2:0]               irq_channel_sel_i,
	input  wire logic [1:0]               irq_point_sel_i,
	input  wire logic                     fault_edge_polarity_i,
	input  wire logic [NUM_CH-1:0]        fault_brake_data_i,
	// fault pin from the power stage
	input  wire logic                     fault_input_i,
	// waveform outputs
	output logic      [NUM_CH-1:0]        pwm_o,
	output logic                          period_event_flag_o,
	output logic                          fault_brake_o
);
	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic             run_enable_q;        // generator running
	logic             reload_pend_q;       // reload waiting for period end
	logic             period_flag_q;       // sticky period event
	logic             clear_pend_q;        // counter clear waiting
	logic [7:0]       mode_cfg_q;          // pwm_mode_config contents
	logic             run_prev_q;          // run_enable one cycle ago
	logic             brake_q;             // fault brake holding outputs
	// ------------------------------------------------------------
	// counter and buffers
	// ------------------------------------------------------------
	logic [CNT_W-1:0] cnt_q;               // 16-bit pwm counter
	logic             down_q;              // center mode counting down
	logic [CNT_W-1:0] period_buf_q;        // working period
	logic [NUM_CH-1:0][CNT_W-1:0] duty_buf_q; // working duties
	logic [6:0]       div_q;               // prescaler count
	logic [NUM_CH-1:0] pg_prev_q;          // raw waveform last tick
	// ------------------------------------------------------------
	// fault pin synchroniser
	// ------------------------------------------------------------
	logic             fsync1_q, fsync2_q, fsync3_q; // stages one (metastable) to three
	logic             fault_lvl_q;         // accepted fault level
	// ------------------------------------------------------------
	// decoded configuration and events
	// ------------------------------------------------------------
	out_mode_t        out_mode;
	irq_point_t       irq_point;
	logic             group_en, center_en, fault_pin_en; // mode_cfg_q fields
	logic [2:0]       prescale;
	logic [6:0]       div_mask;            // ones below the division point
	logic             src_tick;            // pwm source clock enable
	logic             tick;                // divided counter advance
	logic             at_top;              // counter equals period
	logic             period_end;          // last tick of a period
	logic             fault_edge;          // qualified edge on fault pin
	logic             wr_run, wr_mode;     // register write strobes
	logic [NUM_CH-1:0] pg;                 // raw compare waveform
	logic [NUM_CH-1:0] shaped;             // after mode selection
	logic             sel_now, sel_prev;   // flag channel now and last tick
	logic             irq_hit;
	assign out_mode     = out_mode_t'(mode_cfg_q[MODE_SEL_HI:MODE_SEL_LO]);
	assign irq_point    = irq_point_t'(irq_point_sel_i);
	assign group_en     = mode_cfg_q[BIT_GROUP_DUTY];
	assign center_en    = mode_cfg_q[BIT_ALIGN_SEL];
	assign fault_pin_en = mode_cfg_q[BIT_FAULT_PIN_EN];
	assign prescale     = mode_cfg_q[PRESCALE_HI:0];
	assign wr_run       = sfr_req_i.wr && (sfr_req_i.addr == ADDR_RUN_CONTROL);
	assign wr_mode      = sfr_req_i.wr && (sfr_req_i.addr == ADDR_MODE_CONFIG);
	// ------------------------------------------------------------
	// fault pin sampling
	// ------------------------------------------------------------
	// three stages; the level is taken only when stages two and three agree
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fsync1_q    <= 1'b0;
			fsync2_q    <= 1'b0;
			fsync3_q    <= 1'b0;
			fault_lvl_q <= 1'b0;
		end else begin
			fsync1_q <= fault_input_i;
			fsync2_q <= fsync1_q;
			fsync3_q <= fsync2_q;
			if (fsync2_q == fsync3_q) begin
				fault_lvl_q <= fsync3_q;
			end
		end
	end
	// polarity one means a rising edge brakes, zero a falling edge
	assign fault_edge = fault_pin_en && (fsync2_q == fsync3_q) && (fsync3_q != fault_lvl_q)
	                    && (fsync3_q == fault_edge_polarity_i);
	// ------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------
	// mask of ones: division by 2**prescale
	assign div_mask = 7'(({7'h00, 1'b1} << prescale) - 8'h01);
	assign src_tick = pwm_clk_sel_i ? timer_ovf_i : 1'b1;
	assign tick     = run_enable_q && src_tick && ((div_q & div_mask) == div_mask);
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_q <= DIV_ZERO;
		end else if (run_enable_q && !run_prev_q) begin
			div_q <= DIV_ZERO;
		end else if (run_enable_q && src_tick) begin
			div_q <= (tick) ? DIV_ZERO : div_q + 7'h01;
		end
	end
	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	assign at_top     = (cnt_q == period_buf_q);
	// edge: period ends at the top; center: back down at zero
	assign period_end = tick && (center_en ? (down_q && cnt_q == CNT_ZERO) || (period_buf_q == CNT_ZERO)
	                                       : at_top);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q  <= CNT_ZERO;
			down_q <= 1'b0;
		end else if (fault_edge) begin
			cnt_q  <= CNT_ZERO;
			down_q <= 1'b0;
		end else if (clear_pend_q) begin
			cnt_q  <= CNT_ZERO;
			down_q <= 1'b0;
		end else if (tick) begin
			if (!center_en) begin
				cnt_q  <= at_top ? CNT_ZERO : cnt_q + 16'h0001;
				down_q <= 1'b0;
			end else if (!down_q) begin
				// turn round at the top so top and bottom each last one tick
				down_q <= at_top && (period_buf_q != CNT_ZERO);
				cnt_q  <= at_top ? cnt_q - 16'(period_buf_q != CNT_ZERO) : cnt_q + 16'h0001;
			end else if (cnt_q == CNT_ZERO) begin
				down_q <= 1'b0;
				cnt_q  <= (period_buf_q != CNT_ZERO) ? 16'h0001 : CNT_ZERO;
			end else begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end
	// ------------------------------------------------------------
	// period and duty buffers
	// ------------------------------------------------------------
	// only swap at a period boundary so no half-updated cycle appears
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			period_buf_q <= CNT_ZERO;
			duty_buf_q   <= '0;
		end else if (reload_pend_q && period_end) begin
			period_buf_q <= period_i;
			duty_buf_q   <= duty_i;
		end
	end
	// ------------------------------------------------------------
	// compare waveforms, one per channel
	// ------------------------------------------------------------
	// high below the duty: set at zero in edge mode, cleared at the match
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_cmp
			logic [CNT_W-1:0] duty_use;
			assign duty_use = group_en ? duty_buf_q[0] : duty_buf_q[ch];
			assign pg[ch]   = (cnt_q < duty_use);
			// odd channels follow their even partner per mode
			if (ch % 2 == 1) begin : g_odd
				always_comb begin
					case (out_mode)
						MODE_COMPLEMENTARY: shaped[ch] = ~pg[ch-1];
						MODE_SYNCHRONIZED:  shaped[ch] = pg[ch-1];
						default:            shaped[ch] = pg[ch]; // reserved acts as independent
					endcase
				end
			end else begin : g_even
				assign shaped[ch] = pg[ch];
			end
		end
	endgenerate
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// idle drives low; brake drives the brake pattern until restarted
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwm_o <= '0;
		end else if (brake_q || fault_edge) begin
			pwm_o <= fault_brake_data_i;
		end else begin
			pwm_o <= run_enable_q ? shaped : '0;
		end
	end
	// ------------------------------------------------------------
	// interrupt point detection
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pg_prev_q <= '0;
		end else if (tick) begin
			pg_prev_q <= pg;
		end
	end

	// channel choice above five falls back to channel zero
	assign sel_now  = (irq_channel_sel_i < 3'(NUM_CH)) ? pg[irq_channel_sel_i] : pg[0];
	assign sel_prev = (irq_channel_sel_i < 3'(NUM_CH)) ? pg_prev_q[irq_channel_sel_i] : pg_prev_q[0];
	always_comb begin
		irq_hit = 1'b0;
		if (tick) begin
			case (irq_point)
				IRQ_AT_FALL:   irq_hit = sel_prev && !sel_now;
				IRQ_AT_RISE:   irq_hit = !sel_prev && sel_now;
				// center and end points exist only when center-aligned
				IRQ_AT_CENTER: irq_hit = center_en && !down_q && at_top;
				IRQ_AT_END:    irq_hit = center_en && down_q && (cnt_q == CNT_ZERO);
				default:       irq_hit = 1'b0;
			endcase
		end
	end
	// ------------------------------------------------------------
	// pwm_run_control
	// ------------------------------------------------------------
	// run: hardware clear on fault, software set restarts and lifts brake
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_enable_q <= RUN_CONTROL_RESET[BIT_RUN_ENABLE];
			brake_q      <= 1'b0;
		end else if (fault_edge) begin
			run_enable_q <= 1'b0;
			brake_q      <= 1'b1;
		end else if (wr_run) begin
			run_enable_q <= sfr_req_i.wdata[BIT_RUN_ENABLE];
			if (sfr_req_i.wdata[BIT_RUN_ENABLE]) begin
				brake_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_prev_q <= 1'b0;
		end else begin
			run_prev_q <= run_enable_q;
		end
	end
	// reload: a fresh write of one wins over the completing transfer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reload_pend_q <= RUN_CONTROL_RESET[BIT_RELOAD_REQ];
		end else if (wr_run && sfr_req_i.wdata[BIT_RELOAD_REQ]) begin
			reload_pend_q <= 1'b1;
		end else if (reload_pend_q && period_end) begin
			reload_pend_q <= 1'b0;
		end
	end
	// counter clear: taken the cycle after the write, then dropped
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clear_pend_q <= RUN_CONTROL_RESET[BIT_COUNTER_CLEAR];
		end else begin
			clear_pend_q <= wr_run && sfr_req_i.wdata[BIT_COUNTER_CLEAR];
		end
	end

	// flag: writing zero clears, a same-cycle event keeps it set
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			period_flag_q <= RUN_CONTROL_RESET[BIT_PERIOD_FLAG];
		end else if (irq_hit) begin
			period_flag_q <= 1'b1;
		end else if (wr_run && !sfr_req_i.wdata[BIT_PERIOD_FLAG]) begin
			period_flag_q <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// pwm_mode_config
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_cfg_q <= MODE_CONFIG_RESET;
		end else if (wr_mode) begin
			mode_cfg_q <= sfr_req_i.wdata;
		end
	end
	// ------------------------------------------------------------
	// read-back
	// ------------------------------------------------------------
	// unmapped addresses and low nibble of run control read zero
	always_comb begin
		sfr_rdata_o = 8'h00;
		case (sfr_req_i.addr)
			ADDR_RUN_CONTROL: begin
				sfr_rdata_o[BIT_RUN_ENABLE]    = run_enable_q;
				sfr_rdata_o[BIT_RELOAD_REQ]    = reload_pend_q;
				sfr_rdata_o[BIT_PERIOD_FLAG]   = period_flag_q;
				sfr_rdata_o[BIT_COUNTER_CLEAR] = clear_pend_q;
			end
			ADDR_MODE_CONFIG: sfr_rdata_o = mode_cfg_q;
			default:          sfr_rdata_o = 8'h00;
		endcase
	end

	assign period_event_flag_o = period_flag_q;
	assign fault_brake_o       = brake_q;

endmodule

`default_nettype wire

// >>> pwm_core_control_pkg.sv
package pwm_core_control_pkg;

	// ------------------------------------------------------------
	// special-function register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_RUN_CONTROL = 8'hD7; // pwm_run_control
	localparam logic [7:0] ADDR_MODE_CONFIG = 8'hDF; // pwm_mode_config

	// ------------------------------------------------------------
	// pwm_run_control field positions and reset
	// ------------------------------------------------------------
	localparam int BIT_RUN_ENABLE    = 7;
	localparam int BIT_RELOAD_REQ    = 6;
	localparam int BIT_PERIOD_FLAG   = 5;
	localparam int BIT_COUNTER_CLEAR = 4;
	localparam logic [7:0] RUN_CONTROL_RESET = 8'h00;

	// ------------------------------------------------------------
	// pwm_mode_config field positions and reset
	// ------------------------------------------------------------
	localparam int MODE_SEL_HI      = 7;
	localparam int MODE_SEL_LO      = 6;
	localparam int BIT_GROUP_DUTY   = 5;
	localparam int BIT_ALIGN_SEL    = 4;
	localparam int BIT_FAULT_PIN_EN = 3;
	localparam int PRESCALE_HI      = 2;
	localparam logic [7:0] MODE_CONFIG_RESET = 8'h00;

	// ------------------------------------------------------------
	// widths and counts
	// ------------------------------------------------------------
	localparam int NUM_CH    = 6;
	localparam int CNT_W     = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [6:0] DIV_ZERO = 7'h00;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_INDEPENDENT   = 2'b00,
		MODE_COMPLEMENTARY = 2'b01,
		MODE_SYNCHRONIZED  = 2'b10,
		MODE_RESERVED      = 2'b11
	} out_mode_t;

	typedef enum logic [1:0] {
		IRQ_AT_FALL   = 2'b00,
		IRQ_AT_RISE   = 2'b01,
		IRQ_AT_CENTER = 2'b10,
		IRQ_AT_END    = 2'b11
	} irq_point_t;

	// register access from the processor core
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

endpackage

// >>> pwm_core_control_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_core_control_checker
	import pwm_core_control_pkg::*;
(
	// clock and reset
	input wire logic                         sys_clk_i,
	input wire logic                         rst_n_i,
	// register port
	input wire sfr_req_t                     sfr_req_i,
	input wire logic [7:0]                   sfr_rdata_o,
	// sources and settings
	input wire logic                         pwm_clk_sel_i,
	input wire logic                         timer_ovf_i,
	input wire logic [CNT_W-1:0]             period_i,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] duty_i,
	input wire logic [2:0]                   irq_channel_sel_i,
	input wire logic [1:0]                   irq_point_sel_i,
	input wire logic                         fault_edge_polarity_i,
	input wire logic [NUM_CH-1:0]            fault_brake_data_i,
	input wire logic                         fault_input_i,
	// outputs under watch
	input wire logic [NUM_CH-1:0]            pwm_o,
	input wire logic                         period_event_flag_o,
	input wire logic                         fault_brake_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ------------------------------------------------------------
	// decoded register accesses
	// ------------------------------------------------------------
	logic on_run;  // address selects run control
	logic on_cfg;  // address selects mode config
	logic w_run;   // any write to run control
	assign on_run = sfr_req_i.addr == ADDR_RUN_CONTROL;
	assign on_cfg = sfr_req_i.addr == ADDR_MODE_CONFIG;
	assign w_run  = sfr_req_i.wr && on_run;
	// clear request followed by a quiet cycle
	sequence clr_then_quiet;
		(w_run && sfr_req_i.wdata[BIT_COUNTER_CLEAR]) ##1 !(w_run && sfr_req_i.wdata[BIT_COUNTER_CLEAR]);
	endsequence
	// idle seen long enough for the output pipe to drain
	sequence idle_long;
		(on_run && !sfr_rdata_o[BIT_RUN_ENABLE] && !fault_brake_o) [*3];
	endsequence
	a_idle_out_low: assert property (idle_long |-> pwm_o == '0)
		else $error("outputs active while idle");
	a_reload_pend: assert property (w_run && sfr_req_i.wdata[BIT_RELOAD_REQ] |=> !on_run || sfr_rdata_o[BIT_RELOAD_REQ])
		else $error("reload request not pending");
	a_clear_pend: assert property (w_run && sfr_req_i.wdata[BIT_COUNTER_CLEAR] |=> !on_run || sfr_rdata_o[BIT_COUNTER_CLEAR])
		else $error("counter clear not pending");
	a_clear_done: assert property (clr_then_quiet |=> !on_run || !sfr_rdata_o[BIT_COUNTER_CLEAR])
		else $error("counter clear did not finish");
	a_flag_sticky: assert property ($fell(period_event_flag_o) |-> $past(w_run && !sfr_req_i.wdata[BIT_PERIOD_FLAG]) || $past(w_run && !sfr_req_i.wdata[BIT_PERIOD_FLAG], 2))
		else $error("flag dropped without software clear");
	a_brake_stops: assert property ($rose(fault_brake_o) |-> !on_run || !sfr_rdata_o[BIT_RUN_ENABLE])
		else $error("brake left run set");
	a_brake_data: assert property (fault_brake_o && $past(fault_brake_o) |-> pwm_o == $past(fault_brake_data_i))
		else $error("brake pattern not driven");
	a_no_brake_off: assert property (on_cfg && !sfr_rdata_o[BIT_FAULT_PIN_EN] && !fault_brake_o |=> !fault_brake_o)
		else $error("brake while pin disabled");
	a_run_lifts: assert property (fault_brake_o && w_run && sfr_req_i.wdata[BIT_RUN_ENABLE] |=> !fault_brake_o)
		else $error("run write did not lift brake");
	a_cfg_back: assert property (sfr_req_i.wr && on_cfg |=> !on_cfg || sfr_rdata_o == $past(sfr_req_i.wdata))
		else $error("mode config readback wrong");
endmodule
bind pwm_core_control pwm_core_control_checker chk_u (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
	.pwm_clk_sel_i(pwm_clk_sel_i), .timer_ovf_i(timer_ovf_i), .period_i(period_i), .duty_i(duty_i),
	.irq_channel_sel_i(irq_channel_sel_i), .irq_point_sel_i(irq_point_sel_i),
	.fault_edge_polarity_i(fault_edge_polarity_i), .fault_brake_data_i(fault_brake_data_i),
	.fault_input_i(fault_input_i), .pwm_o(pwm_o), .period_event_flag_o(period_event_flag_o),
	.fault_brake_o(fault_brake_o)
);
`default_nettype wire

// >>> motor_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
module motor_stage_model (
	// clock
	input  wire logic sys_clk_i,
	// trip request and the level that means fault
	input  wire logic trip_i,
	input  wire logic active_lvl_i,
	// fault line towards the controller
	output logic      fault_o
);
	int hold_q = 0; // cycles the fault level must still stand
	// hold the fault well past the debounce so it is never filtered away
	always_ff @(posedge sys_clk_i) begin
		if (trip_i) begin
			hold_q <= 12;
		end else if (hold_q > 0) begin
			hold_q <= hold_q - 1;
		end
	end
	// inactive level between trips, edge of chosen polarity on trip
	assign fault_o = (trip_i || hold_q > 0) ? active_lvl_i : !active_lvl_i;
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pwm_core_control_pkg::*;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic                         sys_clk_i, rst_n_i, pol, trip, fault_w, flag, brake, src_sel, ovf;
	logic [2:0]                   ch_sel;
	sfr_req_t                     req;
	logic [7:0]                   rdata, d;
	logic [CNT_W-1:0]             period;
	logic [NUM_CH-1:0][CNT_W-1:0] duty;
	logic [1:0]                   pt_sel;
	logic [NUM_CH-1:0]            fbd, pwm;
	int                           failures, n_compared, rises;
	int                           hi[NUM_CH];
	logic [7:0]                   cfg[8] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h93, 8'h66, 8'h21, 8'h04};
	// timer overflow source and flag channel are stepped by their own scenarios
	pwm_core_control dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
		.pwm_clk_sel_i(src_sel), .timer_ovf_i(ovf), .period_i(period), .duty_i(duty), .irq_channel_sel_i(ch_sel),
		.irq_point_sel_i(pt_sel), .fault_edge_polarity_i(pol), .fault_brake_data_i(fbd),
		.fault_input_i(fault_w), .pwm_o(pwm), .period_event_flag_o(flag), .fault_brake_o(brake));
	motor_stage_model stage_u (.sys_clk_i(sys_clk_i), .trip_i(trip), .active_lvl_i(pol), .fault_o(fault_w));
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#2;
	endtask
	// one-cycle write strobe, data readable on return
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		cyc(1);
		req = '{1'b1, a, v};
		cyc(1);
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		req.addr = a;
		#1;
		d = rdata;
	endtask
	// bounded wait for a level
	task automatic wait_hi(ref logic s, input int n);
		for (int k = 0; k < n && s !== 1'b1; k++) cyc(1);
	endtask
	// high-time per channel and rising edges of channel 0
	task automatic measure(input int n);
		logic p;
		hi = '{default: 0};
		rises = 0;
		p = pwm[0];
		repeat (n) begin
			cyc(1);
			foreach (hi[i]) hi[i] += int'(pwm[i]);
			if (pwm[0] && !p) rises++;
			p = pwm[0];
		end
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rd(ADDR_RUN_CONTROL); chk(16'(d), 16'(RUN_CONTROL_RESET));
		rd(ADDR_MODE_CONFIG); chk(16'(d), 16'(MODE_CONFIG_RESET));
		rd(8'hD8); chk(16'(d), 16'h0000);
		foreach (cfg[i]) begin
			wr(ADDR_MODE_CONFIG, cfg[i]); rd(ADDR_MODE_CONFIG); chk(16'(d), 16'(cfg[i]));
		end
		wr(ADDR_RUN_CONTROL, 8'h2F); rd(ADDR_RUN_CONTROL); chk(16'(d), 16'h0000);
	endtask
	task automatic t_wave();
		wr(ADDR_MODE_CONFIG, 8'h00);
		wr(ADDR_RUN_CONTROL, 8'h40); cyc(20); rd(ADDR_RUN_CONTROL); chk(16'(d[6]), 16'h0001);
		wr(ADDR_RUN_CONTROL, 8'h80); rd(ADDR_RUN_CONTROL); chk(16'(d[7:6]), 16'h0003);
		for (int k = 0; k < 30 && d[6] !== 1'b0; k++) begin cyc(1); rd(ADDR_RUN_CONTROL); end
		chk(16'(d[6]), 16'h0000);
		cyc(3); measure(100);
		chk(16'(hi[0]), 16'h0028); chk(16'(rises), 16'h000A);
		chk(16'(hi[1]), 16'h0014); chk(16'(hi[2]), 16'h003C);
		wr(ADDR_MODE_CONFIG, 8'h40); cyc(4); measure(100);
		chk(16'(hi[1]), 16'h003C); chk(16'(hi[3]), 16'h0028);
		wr(ADDR_MODE_CONFIG, 8'h80); cyc(4); measure(100); chk(16'(hi[1]), 16'h0028);
		wr(ADDR_MODE_CONFIG, 8'h20); cyc(4); measure(100);
		chk(16'(hi[2]), 16'h0028); chk(16'(hi[5]), 16'h0028);
		wr(ADDR_MODE_CONFIG, 8'h01); cyc(20); measure(200); chk(16'(hi[0]), 16'h0050);
		wr(ADDR_MODE_CONFIG, 8'h10); cyc(40); measure(180); chk(16'(rises), 16'h000A);
		wr(ADDR_RUN_CONTROL, 8'h90); rd(ADDR_RUN_CONTROL); chk(16'(d[4]), 16'h0001);
		cyc(1); rd(ADDR_RUN_CONTROL); chk(16'(d[4]), 16'h0000);
		wr(ADDR_RUN_CONTROL, 8'h00); cyc(3); chk(16'(pwm), 16'h0000);
	endtask
	// every flag point in center counting, sticky until cleared
	task automatic t_flag();
		wr(ADDR_RUN_CONTROL, 8'h80);
		for (int p = 0; p < 4; p++) begin
			pt_sel = 2'(p);
			ch_sel = 3'(p);
			wait_hi(flag, 40); chk(16'(flag), 16'h0001);
			cyc(5); chk(16'(flag), 16'h0001);
			wr(ADDR_RUN_CONTROL, 8'h80); cyc(1); chk(16'(flag), 16'h0000);
		end
	endtask
	task automatic t_fault();
		wr(ADDR_MODE_CONFIG, 8'h00);
		trip = 1'b1; cyc(14); trip = 1'b0; cyc(14);
		chk(16'(brake), 16'h0000); rd(ADDR_RUN_CONTROL); chk(16'(d[7]), 16'h0001);
		wr(ADDR_MODE_CONFIG, 8'h08); trip = 1'b1; wait_hi(brake, 20);
		chk(16'(brake), 16'h0001); cyc(1); chk(16'(pwm), 16'h002A);
		rd(ADDR_RUN_CONTROL); chk(16'(d[7]), 16'h0000);
		trip = 1'b0; cyc(20); chk(16'(pwm), 16'h002A);
		wr(ADDR_RUN_CONTROL, 8'h80); cyc(1); chk(16'(brake), 16'h0000);
	endtask
	// timer overflow as source: one pulse every other cycle halves the rate
	task automatic t_src();
		src_sel = 1'b1;
		fork
			begin
				cyc(20);
				measure(200);
			end
			repeat (222) begin
				ovf = ~ovf;
				cyc(1);
			end
		join
		src_sel = 1'b0;
		ovf = 1'b0;
		chk(16'(hi[0]), 16'h0050);
	endtask
	task automatic results();
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		rst_n_i = 1'b0; req = '{1'b0, 8'h00, 8'h00}; pol = 1'b1; trip = 1'b0; pt_sel = 2'h0;
		fbd = 6'h2A; period = 16'h0009; duty = {16'h3, 16'h1, 16'h8, 16'h6, 16'h2, 16'h4};
		src_sel = 1'b0; ovf = 1'b0; ch_sel = 3'h0;
		failures = 0; n_compared = 0;
		cyc(16); rst_n_i = 1'b1;
		t_regs(); t_wave(); t_flag(); t_fault(); t_src();
		results();
	end
	// the tests need fewer than 1500 cycles; this span is far beyond that
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		failures++;
		results();
	end
endmodule
`default_nettype wire
